// ===== verilog/system_clock_manager.sv
// module: clock manager register file, dividers and module clock enables
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module system_clock_manager
	import clk_mgr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// strap from pad
	input wire logic multiplier_config_input,
	// clock enables; the tick outputs pulse once per output clock period, the run outputs and multiplier_used are levels
	output logic mult_in_tick,
	output logic sys_tick,
	output logic bus_tick,
	output logic display_tick,
	output logic [7:0] module_clock_run,
	output logic sdram_clock_run,
	output logic multiplier_used
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] lock_q;
	clk_cfg_t cfg_q;
	gate_a_t gate_a_q;
	logic sdram_stop_q;
	logic cfg_s1_q;
	logic cfg_s2_q;
	logic unlocked;

	assign unlocked = (lock_q == LOCK_KEY);

	// two flops on the asynchronous strap
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_s1_q <= 1'b0;
			cfg_s2_q <= 1'b0;
		end else begin
			cfg_s1_q <= multiplier_config_input;
			cfg_s2_q <= cfg_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data latched independently
	logic aw_have_q;
	logic w_have_q;
	logic [31:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_lane_q;
	logic do_write;
	logic wr_hit;

	function automatic logic [7:0] reg_mask(input logic [31:0] a);
		unique case (a)
			ADDR_LOCK: reg_mask = 8'hFF;
			ADDR_INDIV: reg_mask = MASK_INDIV;
			ADDR_MULT: reg_mask = MASK_MULT;
			ADDR_SRC: reg_mask = MASK_SRC;
			ADDR_BUS: reg_mask = MASK_BUS;
			ADDR_DISP: reg_mask = MASK_DISP;
			ADDR_GATE_A: reg_mask = MASK_GATE_A;
			ADDR_GATE_B: reg_mask = MASK_GATE_B;
			default: reg_mask = 8'h00;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [31:0] a);
		is_mapped = (a >= ADDR_LOCK) && (a <= ADDR_GATE_B);
	endfunction

	// one register per aligned word, data in lane 0; the index drops the byte offset
	function automatic logic [31:0] reg_index(input logic [31:0] a);
		reg_index = {2'b00, a[31:2]};
	endfunction

	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_hit = is_mapped(aw_addr_q);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			if (do_write) begin
				aw_have_q <= 1'b0;
			end else if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= reg_index(s_axi_awaddr);
				s_axi_awready <= 1'b1;
			end
		end
	end

	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= 1'b0;
			if (do_write) begin
				w_have_q <= 1'b0;
			end else if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign w_byte_q = wdata_q[7:0];
	assign w_lane_q = wstrb_q[0];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register updates
	logic wr_en;
	logic [7:0] wv;
	assign wr_en = do_write && wr_hit && w_lane_q;
	assign wv = w_byte_q & reg_mask(aw_addr_q);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lock_q <= RST_LOCK;
		end else if (wr_en && aw_addr_q == ADDR_LOCK) begin
			lock_q <= wv;
		end
	end

	// protected registers change only while the key is held
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_q <= '0;
			cfg_q.input_div <= RST_INDIV;
		end else if (wr_en && unlocked) begin
			unique case (aw_addr_q)
				ADDR_INDIV: cfg_q.input_div <= wv[1:0];
				ADDR_MULT: begin
					cfg_q.powerdown <= wv[1];
					cfg_q.ratio <= wv[0];
				end
				ADDR_SRC: cfg_q.source_sel <= wv[0];
				ADDR_BUS: begin
					cfg_q.bus_en <= wv[BIT_EN];
					cfg_q.bus_ratio <= wv[1:0];
				end
				ADDR_DISP: begin
					cfg_q.disp_en <= wv[BIT_EN];
					cfg_q.disp_ratio <= wv[3:0];
				end
				default: ;
			endcase
		end
	end

	// module gates share the lock with the clock controls
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gate_a_q <= '0;
			sdram_stop_q <= 1'b0;
		end else if (wr_en && unlocked) begin
			if (aw_addr_q == ADDR_GATE_A) begin
				gate_a_q <= wv;
			end
			if (aw_addr_q == ADDR_GATE_B) begin
				sdram_stop_q <= wv[BIT_SDRAM];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, answers in the same cycle the address is taken
	logic [7:0] rd_byte;
	function automatic logic [7:0] read_reg(input logic [31:0] a);
		unique case (a)
			ADDR_LOCK: read_reg = lock_q;
			ADDR_INDIV: read_reg = {6'h00, cfg_q.input_div};
			ADDR_MULT: read_reg = {6'h00, cfg_q.powerdown, cfg_q.ratio};
			ADDR_SRC: read_reg = {7'h00, cfg_q.source_sel};
			ADDR_BUS: read_reg = {cfg_q.bus_en, 5'h00, cfg_q.bus_ratio};
			ADDR_DISP: read_reg = {cfg_q.disp_en, 3'h0, cfg_q.disp_ratio};
			ADDR_GATE_A: read_reg = gate_a_q;
			ADDR_GATE_B: read_reg = {6'h00, sdram_stop_q, 1'b0};
			default: read_reg = 8'h00;
		endcase
	endfunction
	assign rd_byte = read_reg(reg_index(s_axi_araddr));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= is_mapped(reg_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock tree as enable pulses; mclk stands for the oscillator
	logic [1:0] in_term;
	logic in_tick;
	logic use_mult;
	logic [1:0] mult_cnt_q;
	logic mult_tick;
	logic sys_src;
	logic [1:0] bus_term;
	logic bus_t;
	logic disp_t;
	logic run_all;

	assign run_all = 1'b1;
	assign in_term = cfg_q.input_div[1] ? (cfg_q.input_div[0] ? 2'd2 : 2'd1) : 2'd0;

	clk_divider #(.W(2)) u_in_div (
		.mclk(mclk),
		.rst(rst),
		.run(run_all),
		.src_en(1'b1),
		.terminal(in_term),
		.tick(in_tick)
	);

	assign use_mult = !(cfg_s2_q && cfg_q.powerdown);

	// x2 doubles input rate, capped at oscillator rate; x1 follows input
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mult_cnt_q <= 2'd0;
		end else if (in_tick) begin
			mult_cnt_q <= in_term;
		end else if (mult_cnt_q != 2'd0) begin
			mult_cnt_q <= mult_cnt_q - 2'd1;
		end
	end
	assign mult_tick = use_mult ? (in_tick || (cfg_q.ratio && mult_cnt_q == 2'd1)) : 1'b1;

	// switch source only on an input-side tick so no half period appears
	logic src_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			src_q <= 1'b0;
		end else if (in_tick) begin
			src_q <= cfg_q.source_sel;
		end
	end
	assign sys_src = src_q ? mult_tick : 1'b1;

	assign bus_term = cfg_q.bus_ratio[1] ? (cfg_q.bus_ratio[0] ? 2'd3 : 2'd1) : 2'd0;

	clk_divider #(.W(2)) u_bus_div (
		.mclk(mclk),
		.rst(rst),
		.run(cfg_q.bus_en),
		.src_en(sys_src),
		.terminal(bus_term),
		.tick(bus_t)
	);

	clk_divider #(.W(4)) u_disp_div (
		.mclk(mclk),
		.rst(rst),
		.run(cfg_q.disp_en),
		.src_en(sys_src),
		.terminal(cfg_q.disp_ratio),
		.tick(disp_t)
	);

	// gates change only on a source tick, so enables never shorten a period
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			module_clock_run <= 8'hFF;
			sdram_clock_run <= 1'b1;
		end else if (sys_src) begin
			module_clock_run <= ~gate_a_q;
			sdram_clock_run <= ~sdram_stop_q;
		end
	end

	// every enable leaves through a flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mult_in_tick <= 1'b0;
			sys_tick <= 1'b0;
			bus_tick <= 1'b0;
			display_tick <= 1'b0;
			multiplier_used <= 1'b1;
		end else begin
			mult_in_tick <= in_tick;
			sys_tick <= sys_src;
			bus_tick <= bus_t;
			display_tick <= disp_t;
			multiplier_used <= use_mult;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/clk_mgr_pkg.sv
// package: register map, fields, reset values and bus types of the clock manager
// Summary of operation
// - key 0x96 to lock register unlocks; any other value relocks protected registers.
// - input divider code 11 divides by 3, 10 by 2, 0x by 1.
// - input divider field resets to code 10, divide by two.
// - powerdown bit bypasses multiplier when config input is 1; default uses it.
// - ratio bit 1 multiplies by two, 0 by one; resets to 0.
// - source select 1 picks multiplier output, 0 the oscillator; resets 0.
// - bus clock generator runs only while enabled; enable resets to 0.
// - bus ratio 11 divides by four, 10 by two, 0x by one.
// - display clock runs when enabled, frequency is source over ratio plus one.
// - each bit of first gate register stops its module clock when 1.
// - bit 1 of second gate register stops the sdram controller clock.
package clk_mgr_pkg;
	localparam logic [31:0] ADDR_LOCK = 32'h0300F2F;
	localparam logic [31:0] ADDR_INDIV = 32'h0300F30;
	localparam logic [31:0] ADDR_MULT = 32'h0300F31;
	localparam logic [31:0] ADDR_SRC = 32'h0300F32;
	localparam logic [31:0] ADDR_BUS = 32'h0300F33;
	localparam logic [31:0] ADDR_DISP = 32'h0300F34;
	localparam logic [31:0] ADDR_GATE_A = 32'h0300F35;
	localparam logic [31:0] ADDR_GATE_B = 32'h0300F36;
	localparam logic [7:0] LOCK_KEY = 8'h96;
	localparam logic [7:0] RST_LOCK = 8'h00;
	localparam logic [1:0] RST_INDIV = 2'h2;
	localparam logic [7:0] MASK_INDIV = 8'h03;
	localparam logic [7:0] MASK_MULT = 8'h03;
	localparam logic [7:0] MASK_SRC = 8'h01;
	localparam logic [7:0] MASK_BUS = 8'h83;
	localparam logic [7:0] MASK_DISP = 8'h8F;
	localparam logic [7:0] MASK_GATE_A = 8'hFF;
	localparam logic [7:0] MASK_GATE_B = 8'h02;
	localparam int BIT_EN = 7;
	localparam int BIT_SDRAM = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic usb;
		logic serial_bus;
		logic serial_peri;
		logic spi;
		logic media_if;
		logic seq_rom;
		logic arbiter;
		logic display_host;
	} gate_a_t;

	typedef struct packed {
		logic [1:0] input_div;
		logic powerdown;
		logic ratio;
		logic source_sel;
		logic bus_en;
		logic [1:0] bus_ratio;
		logic disp_en;
		logic [3:0] disp_ratio;
	} clk_cfg_t;
endpackage

// ===== verilog/clk_divider.sv
// module: programmable enable-pulse divider with glitch-free ratio change
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic src_en,
	input wire logic [W-1:0] terminal,
	// output
	output logic tick
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] term_q;

	// ratio reloads only at terminal count or while stopped, so no period is cut short
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			term_q <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (!run) begin
				cnt_q <= '0;
				term_q <= terminal;
			end else if (src_en) begin
				if (cnt_q >= term_q) begin
					cnt_q <= '0;
					term_q <= terminal;
					tick <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/system_clock_manager_sva.sv
// checker: bus handshake and clock output properties of the clock manager
`timescale 1ns/1ps
`default_nettype none
module system_clock_manager_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register bus
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock outputs
	input wire logic mult_in_tick,
	input wire logic bus_tick,
	input wire logic display_tick,
	input wire logic [7:0] module_clock_run,
	input wire logic sdram_clock_run,
	input wire logic multiplier_used
);
	default clocking dflt @(posedge mclk); endclocking
	default disable iff (rst);
	// no write answered yet, so reset configuration still holds
	logic wr_seen_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_seen_q <= 1'b0;
		end else if (s_axi_bvalid) begin
			wr_seen_q <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready longer than one cycle");
	chk_resp_follows: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("no write response after address and data");
	chk_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
		else $error("read data missing with address ready");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	chk_reserved_zero: assert property (s_axi_arready && s_axi_araddr == 32'h0C03CCC
		|-> s_axi_rdata[6:2] == 5'h00)
		else $error("reserved bits read nonzero");
	chk_reset_runs: assert property ($fell(rst)
		|-> module_clock_run == 8'hFF && sdram_clock_run && multiplier_used)
		else $error("clock enables wrong after reset");
	chk_idle_gens: assert property (!wr_seen_q |-> !bus_tick && !display_tick)
		else $error("generator ran before being enabled");
	chk_indiv_reset: assert property (!wr_seen_q && mult_in_tick
		|=> !mult_in_tick ##1 mult_in_tick)
		else $error("input divider not halving after reset");
endmodule
bind system_clock_manager system_clock_manager_sva u_sva (
	.mclk, .rst, .s_axi_araddr, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.mult_in_tick, .bus_tick, .display_tick, .module_clock_run, .sdram_clock_run,
	.multiplier_used
);
`default_nettype wire

// ===== testbench/system_clock_manager_tb.sv
// testbench: register access and clock ratio checks of the clock manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module system_clock_manager_tb import clk_mgr_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic multiplier_config_input;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic mult_in_tick, sys_tick, bus_tick, display_tick, sdram_clock_run;
	wire logic multiplier_used;
	wire logic [7:0] module_clock_run;
	wire logic [4:0] tk;
	int errors, n_tests, n;
	int m[8];
	int mk[8];
	logic [7:0] d, g;
	logic [1:0] r;
	assign tk = {display_tick, bus_tick, sys_tick, mult_in_tick, 1'b1};
	always #2.5 mclk = ~mclk;
	system_clock_manager dut (
		.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .multiplier_config_input,
		.mult_in_tick, .sys_tick, .bus_tick, .display_tick, .module_clock_run,
		.sdram_clock_run, .multiplier_used
	);
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tmo();
		errors++;
		test_done();
	endtask
	// model follows the lock: only the lock register itself is always writable
	task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
		int i;
		logic [31:0] k;
		s_axi_awaddr <= {a[29:0], 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 60) tmo();
		rs = s_axi_bresp;
		@(posedge mclk);
		k = a - ADDR_LOCK;
		if (k == 0) m[0] = v;
		else if (k < 8 && m[0] == LOCK_KEY) m[k] = v & mk[k];
	endtask
	task automatic rd(input logic [31:0] a, output logic [7:0] v, output logic [1:0] rs);
		int i;
		s_axi_araddr <= {a[29:0], 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 60) tmo();
		v = s_axi_rdata[7:0];
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	// ticks of rf per period of s; second period, so a change in flight is over
	task automatic per(input int s, input int rf, output int c);
		int i;
		repeat (2) begin
			c = 0;
			for (i = 0; i < 300; i++) begin
				@(negedge mclk);
				if (tk[s]) break;
			end
			if (i == 300) tmo();
			for (i = 0; i < 300; i++) begin
				@(negedge mclk);
				c += tk[rf];
				if (tk[s]) break;
			end
			if (i == 300) tmo();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		s_axi_awaddr = '0;
		s_axi_wdata = '0;
		s_axi_araddr = '0;
		s_axi_wstrb = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_bready = 1'b1;
		multiplier_config_input = 1'b1;
		errors = 0;
		n_tests = 0;
		mk = '{255, 3, 3, 1, 131, 143, 255, 2};
		m = '{0, 2, 0, 0, 0, 0, 0, 0};
		void'($urandom(32'hfb1ac283));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int k = 0; k < 8; k++) begin
			rd(ADDR_LOCK + k, d, r);
			`CHK(d, 8'(m[k]))
		end
		wr(ADDR_BUS, 8'h83, r);
		rd(ADDR_BUS, d, r);
		`CHK(d, 8'(m[4]))
		wr(ADDR_LOCK, LOCK_KEY, r);
		for (int k = 1; k < 8; k++) begin
			wr(ADDR_LOCK + k, 8'($urandom), r);
			rd(ADDR_LOCK + k, d, r);
			`CHK({r, d}, {RESP_OKAY, 8'(m[k])})
		end
		wr(ADDR_LOCK, 8'h55, r);
		wr(ADDR_GATE_A, ~8'(m[6]), r);
		rd(ADDR_GATE_A, d, r);
		`CHK(d, 8'(m[6]))
		wr(32'h0, 8'hFF, r);
		`CHK(r, RESP_SLVERR)
		rd(32'h0, d, r);
		`CHK({r, d}, {RESP_SLVERR, 8'h00})
		wr(ADDR_LOCK, LOCK_KEY, r);
		wr(ADDR_SRC, 8'h00, r);
		g = 8'($urandom);
		wr(ADDR_GATE_A, g, r);
		wr(ADDR_GATE_B, ~g, r);
		per(2, 0, n);
		`CHK(module_clock_run, ~8'(m[6]))
		`CHK(sdram_clock_run, ~m[7][1])
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_INDIV, 8'(c), r);
			per(1, 0, n);
			`CHK(n, (c == 3) ? 3 : (c == 2) ? 2 : 1)
		end
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_BUS, 8'(8'h80 | c), r);
			per(3, 2, n);
			`CHK(n, (c == 3) ? 4 : (c == 2) ? 2 : 1)
		end
		wr(ADDR_BUS, 8'h03, r);
		per(2, 0, n);
		n = 0;
		repeat (40) begin
			@(negedge mclk);
			n += bus_tick;
		end
		`CHK(n, 0)
		for (int c = 0; c < 16; c += 5) begin
			wr(ADDR_DISP, 8'(8'h80 | c), r);
			per(4, 2, n);
			`CHK(n, c + 1)
		end
		wr(ADDR_INDIV, 8'h03, r);
		wr(ADDR_SRC, 8'h01, r);
		for (int c = 0; c < 4; c++) begin
			multiplier_config_input <= (c != 3);
			wr(ADDR_MULT, (c == 0) ? 8'h00 : (c == 1) ? 8'h01 : 8'h02, r);
			per(1, 2, n);
			`CHK(n, (c == 1) ? 2 : (c == 2) ? 3 : 1)
			`CHK(multiplier_used, c != 2)
		end
		test_done();
	end
endmodule
`default_nettype wire
